//--- src/ces_defines.svh
`ifndef CES_DEFINES_SVH
`define CES_DEFINES_SVH
// ==========================================
// event register layout
`define CES_EV_CME 5
`define CES_EV_EXE 4
`define CES_EV_DDE 3
`define CES_EV_QUE 2
`define CES_EV_OPC 0
`define CES_EV_USED 8'h3D
`define CES_ESE_RST 8'h00
`define CES_ESR_RST 8'h00
// ==========================================
// error classes (hundreds digit)
`define CES_CLS_CMD 3'h1
`define CES_CLS_EXE 3'h2
`define CES_CLS_DEV 3'h3
`define CES_CLS_QRY 3'h4
// ==========================================
// calibration store geometry
`define CES_WORDS 8
`define CES_WIDX_W 3
`define CES_AREA_W 3
`define CES_CAL_W 16
`define CES_WIDX_LAST 3'h7
// ==========================================
// password limits
`define CES_PW_MIN 5'h06
`define CES_PW_MAX 5'h14
`endif

//--- src/ces_pkg.sv
`include "ces_defines.svh"
package ces_pkg;
    // ==========================================
    // calibration areas
    typedef enum logic [2:0] {
        AREA_WORK = 3'b000,
        AREA_PRI = 3'b001,
        AREA_OLD = 3'b010,
        AREA_FACT = 3'b011,
        AREA_MAST = 3'b100,
        AREA_FIRST = 3'b101
    } ces_area_t;
    // ==========================================
    // parsed command opcodes
    typedef enum logic [3:0] {
        OP_NONE = 4'b0000,
        OP_COMMIT = 4'b0001,
        OP_DUMP = 4'b0010,
        OP_COPY = 4'b0011,
        OP_MSG_END = 4'b0100,
        OP_CLS = 4'b0101,
        OP_ESE_WR = 4'b0110,
        OP_ESE_RD = 4'b0111,
        OP_ESR_RD = 4'b1000,
        OP_IDN_RD = 4'b1001,
        OP_OPC = 4'b1010,
        OP_PW_CHAR = 4'b1011,
        OP_PW_END = 4'b1100
    } ces_op_t;
    // ==========================================
    // bcd calibration date mm/dd/yyyy
    typedef struct packed {
        logic [7:0] month;
        logic [7:0] day;
        logic [15:0] year;
    } ces_date_t;
    typedef struct packed {
        ces_op_t op;
        ces_area_t area;
        logic [7:0] arg;
        logic date_ok;
        ces_date_t date;
    } ces_cmd_t;
    typedef enum logic [1:0] {
        RSP_INT = 2'b00,
        RSP_IDN = 2'b01
    } ces_rsp_kind_t;
    typedef struct packed {
        ces_rsp_kind_t kind;
        logic [7:0] value;
    } ces_rsp_t;
    // ==========================================
    // store sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RSRC = 3'b001,
        ST_RPRI = 3'b010,
        ST_WOLD = 3'b011,
        ST_WPRI = 3'b100,
        ST_WWRK = 3'b101,
        ST_WDST = 3'b110
    } ces_state_t;
endpackage

//--- src/ces_cal_mem.sv
`timescale 1ns/1ps
`include "ces_defines.svh"
// ==========================================
// calibration word store, registered read
module ces_cal_mem (
    input wire logic clk,
    input wire logic [`CES_AREA_W+`CES_WIDX_W-1:0] rd_addr,
    output logic [`CES_CAL_W-1:0] rd_data,
    input wire logic wr_en,
    input wire logic [`CES_AREA_W+`CES_WIDX_W-1:0] wr_addr,
    input wire logic [`CES_CAL_W-1:0] wr_data
);
    // one row per area and word
    logic [`CES_CAL_W-1:0] mem [0:(1<<(`CES_AREA_W+`CES_WIDX_W))-1];

    // write port
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read data leaves a register
    always_ff @(posedge clk)
    begin
        rd_data <= mem[rd_addr];
    end
endmodule

//--- src/ces_top.sv
`timescale 1ns/1ps
`include "ces_defines.svh"
// ==========================================
// calibration store and event status
module ces_top #(
    parameter bit FACT_PW_EN = 1'b0 // special firmware allows factory overwrite
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cmd_valid,
    input wire ces_pkg::ces_cmd_t cmd,
    input wire logic err_valid,
    input wire logic [2:0] err_class,
    input wire logic out_err,
    input wire logic [`CES_CAL_W-1:0] live_data,
    output logic [`CES_WIDX_W-1:0] live_idx,
    output logic busy,
    output logic rsp_valid,
    output ces_pkg::ces_rsp_t rsp,
    output logic esb,
    output logic err_q_clr,
    output ces_pkg::ces_date_t cal_date,
    output logic unlocked
);
    import ces_pkg::*;

    // ==========================================
    // state
    ces_state_t st_r, st_nxt;
    logic [`CES_WIDX_W-1:0] wi_r; // word index in a walk
    ces_area_t src_r; // dumped source area
    logic src_ok_r; // dump seen in this message
    ces_area_t dst_r; // destination of a plain copy
    logic from_src_r; // rotation takes data from source
    logic [`CES_CAL_W-1:0] hold_r; // source word kept over rotation
    logic [7:0] esr_r, esr_nxt;
    logic [7:0] ese_r, ese_nxt;
    logic esb_r;
    logic busy_r; // walk in progress, registered not-idle
    logic opc_pend_r; // waiting for idle to raise complete
    logic rsp_valid_r;
    ces_rsp_t rsp_r;
    logic err_q_clr_r;
    ces_date_t date_r;
    logic unlock_r;
    // password scan
    logic [4:0] pw_len_r;
    logic pw_alpha_r, pw_num_r, pw_punct_r, pw_bad_r;

    // ==========================================
    // command decode
    wire logic is_commit = cmd_valid && cmd.op == OP_COMMIT;
    wire logic is_dump = cmd_valid && cmd.op == OP_DUMP;
    wire logic is_copy = cmd_valid && cmd.op == OP_COPY;
    wire logic is_end = cmd_valid && cmd.op == OP_MSG_END;
    wire logic is_cls = cmd_valid && cmd.op == OP_CLS;
    wire logic is_ese_wr = cmd_valid && cmd.op == OP_ESE_WR;
    wire logic is_ese_rd = cmd_valid && cmd.op == OP_ESE_RD;
    wire logic is_esr_rd = cmd_valid && cmd.op == OP_ESR_RD;
    wire logic is_idn = cmd_valid && cmd.op == OP_IDN_RD;
    wire logic is_opc = cmd_valid && cmd.op == OP_OPC;
    wire logic is_pw_ch = cmd_valid && cmd.op == OP_PW_CHAR;
    wire logic is_pw_end = cmd_valid && cmd.op == OP_PW_END;
    wire logic idle = st_r == ST_IDLE;
    // areas above first do not exist
    wire logic area_bad = cmd.area > AREA_FIRST;

    // ==========================================
    // store request checks
    // factory destination needs the unlock
    wire logic fact_block = cmd.area == AREA_FACT && !unlock_r;
    // copy without a dump in the same message is a command error
    wire logic copy_nosrc = is_copy && !src_ok_r;
    wire logic copy_go = is_copy && src_ok_r && idle && !fact_block && !area_bad;
    wire logic commit_go = is_commit && idle;
    // busy store or blocked destination is an execution error
    wire logic store_ref = (is_commit && !idle) ||
        (is_copy && src_ok_r && (!idle || fact_block || area_bad));
    wire logic dump_bad = is_dump && area_bad;

    // ==========================================
    // password character classes
    wire logic ch_alpha = cmd.arg >= 8'h41 && cmd.arg <= 8'h5A;
    wire logic ch_num = cmd.arg >= 8'h30 && cmd.arg <= 8'h39;
    wire logic ch_punct = cmd.arg == 8'h21 || cmd.arg == 8'h40 || cmd.arg == 8'h23 ||
        cmd.arg == 8'h24 || cmd.arg == 8'h25 || cmd.arg == 8'h5E ||
        cmd.arg == 8'h26 || cmd.arg == 8'h2A;
    // lower case, space, control and others are refused
    wire logic ch_bad = !(ch_alpha || ch_num || ch_punct);
    wire logic pw_good = pw_len_r >= `CES_PW_MIN && pw_len_r <= `CES_PW_MAX &&
        pw_alpha_r && pw_num_r && pw_punct_r && !pw_bad_r;
    wire logic pw_fail = is_pw_end && !(pw_good && FACT_PW_EN);

    // ==========================================
    // memory wiring
    logic [`CES_CAL_W-1:0] rd_data;
    wire logic last_word = wi_r == `CES_WIDX_LAST;

    // read area per sequencer step
    wire logic [`CES_AREA_W-1:0] rd_area = (st_r == ST_RSRC) ? src_r :
        (st_r == ST_RPRI) ? AREA_PRI : AREA_WORK;
    // write area per sequencer step
    wire logic [`CES_AREA_W-1:0] wr_area = (st_r == ST_WOLD) ? AREA_OLD :
        (st_r == ST_WPRI) ? AREA_PRI :
        (st_r == ST_WDST) ? dst_r : AREA_WORK;
    wire logic wr_en = st_r == ST_WOLD || st_r == ST_WPRI || st_r == ST_WWRK || st_r == ST_WDST;
    // working takes the live table or the kept source word
    wire logic [`CES_CAL_W-1:0] wr_data = (st_r == ST_WWRK) ? (from_src_r ? hold_r : live_data) : rd_data;

    // six areas of words, each kept until rewritten
    ces_cal_mem u_mem (
        .clk(clk),
        .rd_addr({rd_area, wi_r}),
        .rd_data(rd_data),
        .wr_en(wr_en),
        .wr_addr({wr_area, wi_r}),
        .wr_data(wr_data)
    );

    // ==========================================
    // store sequencer next state
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE:
            begin
                if (commit_go)
                    st_nxt = ST_RPRI;
                else if (copy_go)
                    st_nxt = ST_RSRC;
            end
            // source word read first so a prior source survives
            ST_RSRC:
                st_nxt = (dst_r == AREA_WORK) ? ST_RPRI : ST_WDST;
            ST_RPRI:
                st_nxt = ST_WOLD;
            // oldest lost, prior moves down
            ST_WOLD:
                st_nxt = ST_WPRI;
            ST_WPRI:
                st_nxt = ST_WWRK;
            ST_WWRK:
                st_nxt = last_word ? ST_IDLE : (from_src_r ? ST_RSRC : ST_RPRI);
            ST_WDST:
                st_nxt = last_word ? ST_IDLE : ST_RSRC;
            default:
                st_nxt = ST_IDLE;
        endcase
    end

    // ==========================================
    // sequencer registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r <= ST_IDLE;
            wi_r <= '0;
            busy_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            busy_r <= st_nxt != ST_IDLE;
            // word advances after each finished word
            if (st_r == ST_IDLE)
                wi_r <= '0;
            else if (st_r == ST_WWRK || st_r == ST_WDST)
                wi_r <= wi_r + 1'b1;
        end
    end

    // kind of walk latched at start
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            from_src_r <= 1'b0;
            dst_r <= AREA_WORK;
        end
        else if (idle && (commit_go || copy_go))
        begin
            from_src_r <= copy_go;
            dst_r <= copy_go ? cmd.area : AREA_WORK;
        end
    end

    // source word captured one cycle after its read
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            hold_r <= '0;
        else if (st_r == ST_RPRI && from_src_r)
            hold_r <= rd_data;
    end

    // ==========================================
    // dump remembers the source until message end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            src_r <= AREA_WORK;
            src_ok_r <= 1'b0;
        end
        else if (is_dump && !area_bad)
        begin
            src_r <= cmd.area;
            src_ok_r <= 1'b1;
        end
        else if (is_end)
            src_ok_r <= 1'b0;
    end

    // ==========================================
    // commit date kept for identification
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            date_r <= '0;
        else if (commit_go && cmd.date_ok)
            date_r <= cmd.date;
    end

    // ==========================================
    // password scan and unlock
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pw_len_r <= '0;
            pw_alpha_r <= 1'b0;
            pw_num_r <= 1'b0;
            pw_punct_r <= 1'b0;
            pw_bad_r <= 1'b0;
            unlock_r <= 1'b0;
        end
        else if (is_pw_end)
        begin
            // a new password starts fresh
            pw_len_r <= '0;
            pw_alpha_r <= 1'b0;
            pw_num_r <= 1'b0;
            pw_punct_r <= 1'b0;
            pw_bad_r <= 1'b0;
            unlock_r <= pw_good && FACT_PW_EN;
        end
        else if (is_pw_ch)
        begin
            // length saturates past the maximum
            if (pw_len_r <= `CES_PW_MAX)
                pw_len_r <= pw_len_r + 1'b1;
            pw_alpha_r <= pw_alpha_r | ch_alpha;
            pw_num_r <= pw_num_r | ch_num;
            pw_punct_r <= pw_punct_r | ch_punct;
            pw_bad_r <= pw_bad_r | ch_bad;
        end
    end

    // ==========================================
    // event sources
    wire logic ev_cme = (err_valid && err_class == `CES_CLS_CMD) || copy_nosrc || dump_bad;
    wire logic ev_exe = (err_valid && err_class == `CES_CLS_EXE) || store_ref || pw_fail;
    wire logic ev_dde = (err_valid && err_class == `CES_CLS_DEV) || out_err;
    wire logic ev_que = err_valid && err_class == `CES_CLS_QRY;
    wire logic ev_opc = opc_pend_r && idle && !is_opc;
    logic [7:0] ev_set;
    logic [7:0] ev_clr;

    // set vector in register layout
    always_comb
    begin
        ev_set = 8'h00;
        ev_set[`CES_EV_CME] = ev_cme;
        ev_set[`CES_EV_EXE] = ev_exe;
        ev_set[`CES_EV_DDE] = ev_dde;
        ev_set[`CES_EV_QUE] = ev_que;
        ev_set[`CES_EV_OPC] = ev_opc;
    end

    // read or clear-status clears all, operation-complete command bit 0
    always_comb
    begin
        ev_clr = 8'h00;
        if (is_esr_rd || is_cls)
            ev_clr = 8'hFF;
        if (is_opc)
            ev_clr[`CES_EV_OPC] = 1'b1;
    end

    // sticky bits, a new event beats the clear
    assign esr_nxt = ((esr_r & ~ev_clr) | ev_set) & `CES_EV_USED;
    // mask writes only by its own command
    assign ese_nxt = is_ese_wr ? cmd.arg : ese_r;

    // ==========================================
    // event and mask registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            esr_r <= `CES_ESR_RST;
            ese_r <= `CES_ESE_RST;
            esb_r <= 1'b0;
        end
        else
        begin
            esr_r <= esr_nxt;
            // clear-status leaves the mask alone
            ese_r <= ese_nxt;
            esb_r <= |(esr_nxt & ese_nxt);
        end
    end

    // operation complete pending, idled by clear-status
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            opc_pend_r <= 1'b0;
        else if (is_cls)
            opc_pend_r <= 1'b0;
        else if (is_opc)
            opc_pend_r <= 1'b1;
        else if (idle)
            opc_pend_r <= 1'b0;
    end

    // error queue flush pulse
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            err_q_clr_r <= 1'b0;
        else
            err_q_clr_r <= is_cls;
    end

    // ==========================================
    // query answers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rsp_valid_r <= 1'b0;
            rsp_r <= '0;
        end
        else
        begin
            rsp_valid_r <= is_esr_rd || is_ese_rd || is_idn;
            if (is_esr_rd)
                rsp_r <= '{kind: RSP_INT, value: esr_r};
            else if (is_ese_rd)
                rsp_r <= '{kind: RSP_INT, value: ese_r};
            else if (is_idn)
                rsp_r <= '{kind: RSP_IDN, value: 8'h00};
        end
    end

    // ==========================================
    // outputs
    assign live_idx = wi_r;
    assign busy = busy_r;
    assign rsp_valid = rsp_valid_r;
    assign rsp = rsp_r;
    assign esb = esb_r;
    assign err_q_clr = err_q_clr_r;
    assign cal_date = date_r;
    assign unlocked = unlock_r;
endmodule

//--- testbench/ces_top_asserts.sv
`timescale 1ns/1ps
`include "ces_defines.svh"
// ==========================================
// port checker for the store and event block
module ces_top_asserts #(
    parameter bit FACT_PW_EN = 1'b0 // factory unlock allowed
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cmd_valid,
    input wire ces_pkg::ces_cmd_t cmd,
    input wire logic err_valid,
    input wire logic [2:0] err_class,
    input wire logic out_err,
    input wire logic [`CES_CAL_W-1:0] live_data,
    input wire logic [`CES_WIDX_W-1:0] live_idx,
    input wire logic busy,
    input wire logic rsp_valid,
    input wire ces_pkg::ces_rsp_t rsp,
    input wire logic esb,
    input wire logic err_q_clr,
    input wire ces_pkg::ces_date_t cal_date,
    input wire logic unlocked
);
    import ces_pkg::*;
    logic [7:0] mask_r; // own copy of the enable mask
    logic [7:0] run_r; // length of current busy run
    wire logic clr_ev = cmd_valid && (cmd.op == OP_ESR_RD || cmd.op == OP_CLS || cmd.op == OP_ESE_WR);
    wire logic is_int_q = cmd_valid && (cmd.op == OP_ESR_RD || cmd.op == OP_ESE_RD);
    wire logic opc_cmd = cmd_valid && cmd.op == OP_OPC; // drops completion bit legally
    // ==========================================
    // helper state
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mask_r <= 8'h00;
            run_r <= 8'h00;
        end
        else
        begin
            if (cmd_valid && cmd.op == OP_ESE_WR)
                mask_r <= cmd.arg;
            run_r <= busy ? run_r + 8'h01 : 8'h00;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ==========================================
    // store walks and refusals
    a_factory_locked: assert property (FACT_PW_EN == 1'b0 |-> !unlocked)
        else $error("factory area unlocked");
    a_refuse_factory: assert property (cmd_valid && cmd.op == OP_COPY && cmd.area == AREA_FACT && !unlocked
        && !busy |=> !busy [*2]) else $error("copy to factory started a walk");
    a_commit_starts: assert property (cmd_valid && cmd.op == OP_COMMIT && !busy |-> ##[1:2] busy)
        else $error("commit did not start");
    a_walk_length: assert property ($fell(busy) |-> run_r == 8'h10 || run_r == 8'h20 || run_r == 8'h28)
        else $error("walk length wrong");
    // ==========================================
    // event status and answers
    a_clear_pulse: assert property (cmd_valid && cmd.op == OP_CLS |-> ##[1:2] err_q_clr)
        else $error("queue clear missing");
    a_query_answer: assert property (is_int_q |-> ##[1:2] (rsp_valid && rsp.kind == RSP_INT))
        else $error("integer answer missing");
    a_mask_readback: assert property (cmd_valid && cmd.op == OP_ESE_RD |-> ##[1:2] rsp.value == mask_r)
        else $error("mask readback wrong");
    a_ident_answer: assert property (cmd_valid && cmd.op == OP_IDN_RD |-> ##[1:2] (rsp_valid && rsp.kind == RSP_IDN))
        else $error("identification answer missing");
    a_mask_quiet: assert property (mask_r == 8'h00 && $past(mask_r) == 8'h00 |-> !esb)
        else $error("summary set with empty mask");
    a_cmd_summary: assert property (err_valid && err_class == 3'h1 && mask_r[5] && !clr_ev |=> esb)
        else $error("command error not summarised");
    a_dev_summary: assert property (out_err && mask_r[3] && !clr_ev |=> esb)
        else $error("output error not summarised");
    a_event_sticky: assert property (esb && !clr_ev && !opc_cmd && !$past(clr_ev) |=> esb)
        else $error("summary dropped without read");
endmodule
bind ces_top ces_top_asserts #(.FACT_PW_EN(FACT_PW_EN)) u_asserts (
    .clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd(cmd), .err_valid(err_valid),
    .err_class(err_class), .out_err(out_err), .live_data(live_data), .live_idx(live_idx),
    .busy(busy), .rsp_valid(rsp_valid), .rsp(rsp), .esb(esb), .err_q_clr(err_q_clr),
    .cal_date(cal_date), .unlocked(unlocked)
);

//--- testbench/ces_live_src.sv
`timescale 1ns/1ps
`include "ces_defines.svh"
// ==========================================
// live calibration source read by the walk
module ces_live_src (
    input wire logic [`CES_WIDX_W-1:0] live_idx,
    input wire logic [7:0] gen,
    output logic [`CES_CAL_W-1:0] live_data
);
    // pattern plus index, so every word differs
    assign live_data = {gen, 5'h00, live_idx};
endmodule

//--- testbench/tb.sv
`timescale 1ns/1ps
`include "ces_defines.svh"
// ==========================================
// bench for the store and event block
module tb;
    import ces_pkg::*;
    logic clk = 1'b0; // 40 MHz
    logic rst_b = 1'b0; // held low at start
    logic cmd_valid = 1'b0;
    ces_cmd_t cmd = '0;
    logic err_valid = 1'b0;
    logic [2:0] err_class = 3'h0;
    logic out_err = 1'b0;
    logic [7:0] gen = 8'h00; // live word pattern
    logic [`CES_CAL_W-1:0] live_data;
    logic [`CES_WIDX_W-1:0] live_idx;
    logic busy, rsp_valid, esb, err_q_clr, unlocked;
    ces_rsp_t rsp;
    ces_date_t cal_date;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [7:0] v; // last answer value
    ces_rsp_kind_t k; // last answer kind
    int i, j, n;
    string pw = "A1!BCD"; // well formed password
    always #12.5 clk = ~clk;
    ces_top dut (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd(cmd), .err_valid(err_valid),
        .err_class(err_class), .out_err(out_err), .live_data(live_data), .live_idx(live_idx),
        .busy(busy), .rsp_valid(rsp_valid), .rsp(rsp), .esb(esb), .err_q_clr(err_q_clr),
        .cal_date(cal_date), .unlocked(unlocked));
    ces_live_src src (.live_idx(live_idx), .gen(gen), .live_data(live_data));
    logic unl_open; // unlock of the copy built with factory unlock allowed
    ces_top #(.FACT_PW_EN(1'b1)) dut_pw (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd(cmd),
        .err_valid(err_valid), .err_class(err_class), .out_err(out_err), .live_data(live_data), .live_idx(),
        .busy(), .rsp_valid(), .rsp(), .esb(), .err_q_clr(), .cal_date(), .unlocked(unl_open));
    // ==========================================
    // compare tasks and verdict
    task chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task chk_bit(input string nm, input logic exp, input logic got);
        chk_val(nm, {31'h0, exp}, {31'h0, got});
    endtask
    task test_done;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ==========================================
    // command port access
    task send(input ces_op_t op, input logic [2:0] ar, input logic [7:0] arg);
        @(posedge clk);
        #1;
        cmd.op = op;
        cmd.area = ces_area_t'(ar);
        cmd.arg = arg;
        cmd_valid = 1'b1;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
    endtask
    task pulse(input logic [2:0] c, input logic oe);
        @(posedge clk);
        #1;
        err_valid = (c != 3'h0);
        err_class = c;
        out_err = oe;
        @(posedge clk);
        #1;
        err_valid = 1'b0;
        out_err = 1'b0;
    endtask
    task ask(input ces_op_t op);
        send(op, 3'h0, 8'h00);
        n = 0;
        while (rsp_valid !== 1'b1 && n < 4)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        v = rsp.value;
        k = rsp.kind;
        chk_bit("rsp_valid", 1'b1, rsp_valid);
    endtask
    task standard_event_flags(input logic [7:0] exp, input logic [7:0] m);
        ask(OP_ESR_RD);
        chk_val("event flags", exp, v & m);
    endtask
    // wait some edges, then step off the edge
    task tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    // count busy cycles of one walk; cmp off only waits
    task walk(input int exp, input bit cmp);
        n = 0;
        i = 0;
        while (i < 64 && (busy === 1'b1 || i < 3))
        begin
            n += (busy === 1'b1);
            @(posedge clk);
            #1;
            i++;
        end
        if (cmp)
            chk_val("walk cycles", exp, n);
    endtask
    // ==========================================
    // main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        #1;
        rst_b = 1'b1;
        chk_bit("unlocked", 1'b0, unlocked);
        ask(OP_ESE_RD);
        chk_val("mask", 8'h00, v);
        standard_event_flags(8'h00, 8'hFE);
        for (j = 1; j < 5; j++)
        begin
            pulse(j[2:0], 1'b0);
            standard_event_flags(8'h01 << (6 - j), 8'hFE);
            standard_event_flags(8'h00, 8'hFE);
        end
        pulse(3'h0, 1'b1);
        standard_event_flags(8'h08, 8'hFE);
        send(OP_ESE_WR, 3'h0, 8'h3C);
        ask(OP_ESE_RD);
        chk_val("mask", 8'h3C, v);
        pulse(3'h2, 1'b0);
        tick(5);
        chk_bit("summary", 1'b1, esb);
        send(OP_ESE_WR, 3'h0, 8'h20);
        tick(2);
        chk_bit("summary", 1'b0, esb);
        send(OP_ESE_WR, 3'h0, 8'hFF);
        tick(2);
        chk_bit("summary", 1'b1, esb);
        send(OP_CLS, 3'h0, 8'h00);
        n = 0;
        repeat (3)
        begin
            n += (err_q_clr === 1'b1);
            @(posedge clk);
            #1;
        end
        chk_val("queue clear", 1, n);
        chk_bit("summary", 1'b0, esb);
        ask(OP_ESE_RD);
        chk_val("mask", 8'hFF, v);
        standard_event_flags(8'h00, 8'hFE);
        pulse(3'h1, 1'b1);
        chk_bit("summary", 1'b1, esb);
        standard_event_flags(8'h28, 8'hFE);
        send(OP_ESE_WR, 3'h0, 8'h00);
        // walks: commit, copy into working, copy elsewhere
        gen = 8'hA5;
        cmd.date = {8'h12, 8'h21, 16'h2003};
        cmd.date_ok = 1'b1;
        send(OP_COMMIT, 3'h0, 8'h00);
        walk(32, 1'b1);
        chk_val("working word", 16'hA507, dut.u_mem.mem[6'h07]);
        cmd.date_ok = 1'b0;
        ask(OP_IDN_RD);
        chk_val("ident kind", RSP_IDN, k);
        chk_val("cal date", 32'h12212003, cal_date);
        send(OP_DUMP, 3'h1, 8'h00);
        send(OP_COPY, 3'h0, 8'h00);
        walk(40, 1'b1);
        chk_val("prior word", 16'hA502, dut.u_mem.mem[6'h0A]);
        send(OP_DUMP, 3'h0, 8'h00);
        send(OP_COPY, 3'h4, 8'h00);
        walk(16, 1'b1);
        send(OP_MSG_END, 3'h0, 8'h00);
        // refusals
        send(OP_DUMP, 3'h3, 8'h00);
        send(OP_COPY, 3'h3, 8'h00);
        walk(0, 1'b1);
        standard_event_flags(8'h10, 8'hFE);
        send(OP_MSG_END, 3'h0, 8'h00);
        send(OP_COPY, 3'h0, 8'h00);
        walk(0, 1'b1);
        standard_event_flags(8'h20, 8'hFE);
        send(OP_DUMP, 3'h6, 8'h00);
        standard_event_flags(8'h20, 8'hFE);
        send(OP_DUMP, 3'h0, 8'h00);
        send(OP_COPY, 3'h6, 8'h00);
        walk(0, 1'b1);
        standard_event_flags(8'h10, 8'hFE);
        send(OP_MSG_END, 3'h0, 8'h00);
        gen = 8'h5A;
        send(OP_COMMIT, 3'h0, 8'h00);
        send(OP_COMMIT, 3'h0, 8'h00);
        standard_event_flags(8'h10, 8'hFE);
        walk(0, 1'b0);
        chk_val("working word", 16'h5A03, dut.u_mem.mem[6'h03]);
        chk_val("oldest word", 16'hA503, dut.u_mem.mem[6'h13]);
        for (j = 0; j < 6; j++)
            send(OP_PW_CHAR, 3'h0, pw[j]);
        send(OP_PW_END, 3'h0, 8'h00);
        standard_event_flags(8'h10, 8'hFE);
        chk_bit("unlocked", 1'b0, unlocked);
        chk_bit("unlocked open", 1'b1, unl_open);
        // same password in lower case must be refused
        for (j = 0; j < 6; j++)
            send(OP_PW_CHAR, 3'h0, pw[j] | 8'h20);
        send(OP_PW_END, 3'h0, 8'h00);
        chk_bit("unlocked open", 1'b0, unl_open);
        // completion flag across a walk
        send(OP_COMMIT, 3'h0, 8'h00);
        send(OP_OPC, 3'h0, 8'h00);
        standard_event_flags(8'h00, 8'h01);
        walk(0, 1'b0);
        repeat (2) @(posedge clk);
        standard_event_flags(8'h01, 8'h01);
        test_done;
    end
    // ==========================================
    // watchdog against a hang
    initial
    begin
        #150000;
        n_mismatch++;
        test_done;
    end
endmodule
